// *** design/drscr_regs.sv ***
// two-wire serial register bank for sync, holdover and key-port control
`timescale 1ns/1ps
// Operation
// - vsync output: raw or separator, under override
// - override bit hands vsync choice to host
// - holdover source: external pin or vsync
// - power-down bit is active low
// - separator toggles after threshold cycles, reset 0x20
// - scan enable bit, resets to zero
// - holdover polarity: detected or host bit 5
// - hsync polarity: detected or host bit 7
// - polarity status in bits seven to five
// - slicer threshold bits 7:3, reset 10111
// - pre-holdover line count, resets to zero
// - post-holdover line count, resets to zero
// - format bit selects 4:4:4 or 4:2:2
// - key status reads one when keys found
// - key port address 0x74 or 0x76
// - shared pin: control output three or key data
// - key bus released when drive bit zero
// - oscillator bit: internal one, external zero
module drscr_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h4c // arbitrary value
) (
  input wire logic sys_clk,
  input wire logic rst,
  // two-wire serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // sync sources
  input wire logic raw_vsync,
  input wire logic composite_sync,
  input wire logic holdover_pin,
  input wire logic auto_vsync_from_sep,
  output logic vsync_out,
  output logic sep_sync_out,
  output logic holdover_src,
  // polarity
  input wire logic host_hsync_pol,
  input wire logic host_holdover_pol,
  input wire logic det_hsync_pol,
  input wire logic det_holdover_pol,
  input wire logic vsync_out_pol,
  output logic hsync_pol,
  output logic holdover_pol,
  // key port
  input wire logic keys_detected,
  input wire logic key_data_drive,
  input wire logic key_clock_drive,
  input wire logic general_control_output_three,
  output logic [6:0] key_port_addr,
  output logic shared_pin_out,
  output logic shared_pin_oe,
  output logic key_memory_clock_out,
  output logic key_memory_clock_oe,
  output logic osc_use_internal,
  output drscr_pkg::drscr_cfg_s cfg
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  wire logic scl_q = pin_sync_reg[0];
  wire logic sda_q = pin_sync_reg[1];
  wire logic csync_q = pin_sync_reg[2];

  always_ff @(posedge sys_clk) begin
    pin_meta_reg <= {composite_sync, sda_in, scl_in};
    pin_sync_reg <= pin_meta_reg;
    scl_d_reg <= pin_sync_reg[0];
    sda_d_reg <= pin_sync_reg[1];
  end

  wire logic scl_rise = scl_q & ~scl_d_reg;
  wire logic scl_fall = ~scl_q & scl_d_reg;
  wire logic bus_start = scl_q & scl_d_reg & sda_d_reg & ~sda_q;
  wire logic bus_stop = scl_q & scl_d_reg & ~sda_d_reg & sda_q;

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [3:0] iface_sync_reg;
  logic [7:0] sep_thresh_reg;
  logic [7:0] misc_a_reg;
  logic [7:0] slicer_reg;
  logic [7:0] hold_pre_reg;
  logic [7:0] hold_post_reg;
  logic [7:0] test_reg;
  logic [7:0] loop_a_reg;
  logic [7:0] loop_gain_reg;
  logic [7:0] chroma_reg;
  logic [7:0] fixed_b_reg;
  logic [7:0] fixed_c_reg;
  logic [7:0] key_port_reg;

  // ---------------------------------------------------------------
  // serial slave
  // ---------------------------------------------------------------
  drscr_pkg::drscr_state_e state_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [3:0] cnt_reg;
  logic [7:0] ptr_reg;
  logic rw_reg;
  logic oe_reg;
  logic wr_en_reg;
  logic [7:0] wr_addr_reg;
  logic [7:0] wr_data_reg;
  logic [7:0] rd_data;

  wire logic byte_full = (cnt_reg == 4'h8);
  wire logic addr_match = (shift_reg[7:1] == DEV_ADDR);

  always_ff @(posedge sys_clk) begin
    wr_en_reg <= 1'b0;
    if (rst) begin
      state_reg <= drscr_pkg::ST_IDLE;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      cnt_reg <= 4'h0;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      oe_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      wr_data_reg <= 8'h00;
    end else if (bus_start) begin
      state_reg <= drscr_pkg::ST_ADDR;
      cnt_reg <= 4'h0;
      oe_reg <= 1'b0;
    end else if (bus_stop) begin
      state_reg <= drscr_pkg::ST_IDLE;
      oe_reg <= 1'b0;
    end else if (scl_rise) begin
      case (state_reg)
        drscr_pkg::ST_ADDR, drscr_pkg::ST_SUB, drscr_pkg::ST_WR: begin
          shift_reg <= {shift_reg[6:0], sda_q};
          cnt_reg <= cnt_reg + 4'h1;
        end
        drscr_pkg::ST_RD_ACK: begin
          // master nack ends the read burst
          if (sda_q) begin
            state_reg <= drscr_pkg::ST_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (state_reg)
        drscr_pkg::ST_ADDR: begin
          if (byte_full) begin
            cnt_reg <= 4'h0;
            if (addr_match) begin
              state_reg <= drscr_pkg::ST_ADDR_ACK;
              rw_reg <= shift_reg[0];
              oe_reg <= 1'b1;
            end else begin
              state_reg <= drscr_pkg::ST_IDLE;
            end
          end
        end
        drscr_pkg::ST_ADDR_ACK, drscr_pkg::ST_RD_ACK: begin
          if (state_reg == drscr_pkg::ST_RD_ACK || rw_reg) begin
            tx_reg <= rd_data;
            oe_reg <= ~rd_data[7];
            ptr_reg <= ptr_reg + 8'h01;
            cnt_reg <= 4'h1;
            state_reg <= drscr_pkg::ST_RD;
          end else begin
            oe_reg <= 1'b0;
            state_reg <= drscr_pkg::ST_SUB;
          end
        end
        drscr_pkg::ST_SUB: begin
          if (byte_full) begin
            ptr_reg <= shift_reg;
            cnt_reg <= 4'h0;
            oe_reg <= 1'b1;
            state_reg <= drscr_pkg::ST_SUB_ACK;
          end
        end
        drscr_pkg::ST_WR: begin
          if (byte_full) begin
            wr_en_reg <= 1'b1;
            wr_addr_reg <= ptr_reg;
            wr_data_reg <= shift_reg;
            ptr_reg <= ptr_reg + 8'h01;
            cnt_reg <= 4'h0;
            oe_reg <= 1'b1;
            state_reg <= drscr_pkg::ST_WR_ACK;
          end
        end
        drscr_pkg::ST_SUB_ACK, drscr_pkg::ST_WR_ACK: begin
          oe_reg <= 1'b0;
          state_reg <= drscr_pkg::ST_WR;
        end
        drscr_pkg::ST_RD: begin
          if (byte_full) begin
            oe_reg <= 1'b0;
            state_reg <= drscr_pkg::ST_RD_ACK;
          end else begin
            oe_reg <= ~tx_reg[3'(4'h7 - cnt_reg)];
            cnt_reg <= cnt_reg + 4'h1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = oe_reg;

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  wire logic wr_iface = wr_en_reg && (wr_addr_reg == drscr_pkg::OFS_IFACE_SYNC);
  wire logic wr_sep = wr_en_reg && (wr_addr_reg == drscr_pkg::OFS_SEP_THRESH);
  wire logic wr_misc = wr_en_reg && (wr_addr_reg == drscr_pkg::OFS_MISC_A);
  wire logic wr_slicer = wr_en_reg && (wr_addr_reg == drscr_pkg::OFS_SLICER);
  wire logic wr_pre = wr_en_reg && (wr_addr_reg == drscr_pkg::OFS_HOLD_PRE);
  wire logic wr_post = wr_en_reg && (wr_addr_reg == drscr_pkg::OFS_HOLD_POST);
  wire logic wr_test = wr_en_reg && (wr_addr_reg == drscr_pkg::OFS_TEST);
  wire logic wr_loop_a = wr_en_reg && (wr_addr_reg == drscr_pkg::OFS_LOOP_A);
  wire logic wr_gain = wr_en_reg && (wr_addr_reg == drscr_pkg::OFS_LOOP_GAIN);
  wire logic wr_chroma = wr_en_reg && (wr_addr_reg == drscr_pkg::OFS_CHROMA);
  wire logic wr_fixed_b = wr_en_reg && (wr_addr_reg == drscr_pkg::OFS_FIXED_B);
  wire logic wr_fixed_c = wr_en_reg && (wr_addr_reg == drscr_pkg::OFS_FIXED_C);
  wire logic wr_key = wr_en_reg && (wr_addr_reg == drscr_pkg::OFS_KEY_PORT);

  // status offsets have no write decode at all
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      iface_sync_reg <= drscr_pkg::RST_IFACE_SYNC;
      sep_thresh_reg <= drscr_pkg::RST_SEP_THRESH;
      misc_a_reg <= drscr_pkg::RST_MISC_A;
      slicer_reg <= drscr_pkg::RST_SLICER;
      hold_pre_reg <= drscr_pkg::RST_HOLD_PRE;
      hold_post_reg <= drscr_pkg::RST_HOLD_POST;
      test_reg <= drscr_pkg::RST_TEST;
      loop_a_reg <= drscr_pkg::RST_LOOP_A;
      loop_gain_reg <= drscr_pkg::RST_LOOP_GAIN;
      chroma_reg <= drscr_pkg::RST_CHROMA;
      fixed_b_reg <= drscr_pkg::RST_FIXED_B;
      fixed_c_reg <= drscr_pkg::RST_FIXED_C;
      key_port_reg <= drscr_pkg::RST_KEY_PORT;
    end else begin
      if (wr_iface) iface_sync_reg <= wr_data_reg[3:0];
      if (wr_sep) sep_thresh_reg <= wr_data_reg;
      if (wr_misc) misc_a_reg <= wr_data_reg;
      if (wr_slicer) slicer_reg <= wr_data_reg;
      if (wr_pre) hold_pre_reg <= wr_data_reg;
      if (wr_post) hold_post_reg <= wr_data_reg;
      if (wr_test) test_reg <= wr_data_reg;
      if (wr_loop_a) loop_a_reg <= wr_data_reg;
      if (wr_gain) loop_gain_reg <= wr_data_reg;
      if (wr_chroma) chroma_reg <= wr_data_reg;
      if (wr_fixed_b) fixed_b_reg <= wr_data_reg;
      if (wr_fixed_c) fixed_c_reg <= wr_data_reg;
      if (wr_key) key_port_reg <= wr_data_reg;
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  wire logic [7:0] pol_status = {det_hsync_pol, vsync_out_pol, det_holdover_pol, 5'h00};

  always_comb begin
    if (ptr_reg == drscr_pkg::OFS_IFACE_SYNC) rd_data = {4'h0, iface_sync_reg};
    else if (ptr_reg == drscr_pkg::OFS_SEP_THRESH) rd_data = sep_thresh_reg;
    else if (ptr_reg == drscr_pkg::OFS_MISC_A) rd_data = misc_a_reg;
    else if (ptr_reg == drscr_pkg::OFS_POL_STAT) rd_data = pol_status;
    else if (ptr_reg == drscr_pkg::OFS_SLICER) rd_data = slicer_reg;
    else if (ptr_reg == drscr_pkg::OFS_HOLD_PRE) rd_data = hold_pre_reg;
    else if (ptr_reg == drscr_pkg::OFS_HOLD_POST) rd_data = hold_post_reg;
    else if (ptr_reg == drscr_pkg::OFS_TEST) rd_data = test_reg;
    else if (ptr_reg == drscr_pkg::OFS_LOOP_A) rd_data = loop_a_reg;
    else if (ptr_reg == drscr_pkg::OFS_LOOP_GAIN) rd_data = loop_gain_reg;
    else if (ptr_reg == drscr_pkg::OFS_CHROMA) rd_data = chroma_reg;
    else if (ptr_reg == drscr_pkg::OFS_KEY_STAT) rd_data = {7'h00, keys_detected};
    else if (ptr_reg == drscr_pkg::OFS_FIXED_B) rd_data = fixed_b_reg;
    else if (ptr_reg == drscr_pkg::OFS_FIXED_C) rd_data = fixed_c_reg;
    else if (ptr_reg == drscr_pkg::OFS_KEY_PORT) rd_data = key_port_reg;
    else rd_data = 8'h00;
  end

  // ---------------------------------------------------------------
  // sync separator
  // ---------------------------------------------------------------
  logic [7:0] sep_cnt_reg;
  logic sep_out_reg;
  wire logic sep_differs = (csync_q != sep_out_reg);
  wire logic sep_flip = sep_differs && ((sep_cnt_reg + 8'h01) >= sep_thresh_reg);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sep_cnt_reg <= 8'h00;
      sep_out_reg <= 1'b0;
    end else if (sep_flip) begin
      sep_cnt_reg <= 8'h00;
      sep_out_reg <= ~sep_out_reg;
    end else if (sep_differs) begin
      sep_cnt_reg <= sep_cnt_reg + 8'h01;
    end else begin
      sep_cnt_reg <= 8'h00;
    end
  end

  assign sep_sync_out = sep_out_reg;

  // ---------------------------------------------------------------
  // sync and polarity selection
  // ---------------------------------------------------------------
  wire logic vsync_ovr = iface_sync_reg[drscr_pkg::BIT_VSYNC_OVR];
  wire logic vsync_use_sep = vsync_ovr ? iface_sync_reg[drscr_pkg::BIT_VSYNC_SEL] :
                             auto_vsync_from_sep;
  assign vsync_out = vsync_use_sep ? sep_out_reg : raw_vsync;
  assign holdover_src = iface_sync_reg[drscr_pkg::BIT_HOLD_SRC] ? vsync_out :
                        holdover_pin;
  assign holdover_pol = misc_a_reg[drscr_pkg::BIT_HOLD_POL_OVR] ? host_holdover_pol :
                        det_holdover_pol;
  assign hsync_pol = misc_a_reg[drscr_pkg::BIT_HSYNC_POL_OVR] ? host_hsync_pol :
                     det_hsync_pol;

  // ---------------------------------------------------------------
  // key port and pin control
  // ---------------------------------------------------------------
  wire logic key_drive = key_port_reg[drscr_pkg::BIT_KEY_DRIVE];
  wire logic pin_is_key = key_port_reg[drscr_pkg::BIT_PIN_SEL];

  assign key_port_addr = key_port_reg[drscr_pkg::BIT_KEY_ADDR] ?
                         drscr_pkg::KEY_ADDR_HI[7:1] : drscr_pkg::KEY_ADDR_LO[7:1];
  assign shared_pin_out = pin_is_key ? 1'b0 : general_control_output_three;
  assign shared_pin_oe = pin_is_key ? (key_drive & key_data_drive) : 1'b1;
  assign key_memory_clock_out = 1'b0;
  assign key_memory_clock_oe = key_drive & key_clock_drive;
  assign osc_use_internal = key_port_reg[drscr_pkg::BIT_OSC_INT];

  // ---------------------------------------------------------------
  // configuration outputs
  // ---------------------------------------------------------------
  always_comb begin
    cfg.loop_config_a = loop_a_reg;
    cfg.loop_gain_mode = loop_gain_reg;
    cfg.loop_gain_b = chroma_reg[7:3];
    cfg.slicer_threshold = slicer_reg[7:3];
    cfg.holdover_pre_lines = hold_pre_reg;
    cfg.holdover_post_lines = hold_post_reg;
    cfg.factory_test = test_reg;
    cfg.fixed_b = fixed_b_reg;
    cfg.fixed_c = fixed_c_reg;
    cfg.scan_enable = misc_a_reg[drscr_pkg::BIT_SCAN_EN];
    cfg.output_444 = chroma_reg[drscr_pkg::BIT_FMT_444];
    cfg.cbcr_order = chroma_reg[drscr_pkg::BIT_CBCR_ORDER];
    cfg.sampling_alt = chroma_reg[1];
    cfg.bandwidth_low = key_port_reg[drscr_pkg::BIT_BW_CTRL];
    cfg.osc_internal = key_port_reg[drscr_pkg::BIT_OSC_INT];
    cfg.full_power_down_n = iface_sync_reg[drscr_pkg::BIT_PWR_N];
  end

endmodule // drscr_regs

// *** include/drscr_pkg.sv ***
// constants and types for the sync, holdover and key-port register bank
package drscr_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_IFACE_SYNC = 8'h12;
  localparam logic [7:0] OFS_SEP_THRESH = 8'h13;
  localparam logic [7:0] OFS_MISC_A = 8'h14;
  localparam logic [7:0] OFS_POL_STAT = 8'h15;
  localparam logic [7:0] OFS_SLICER = 8'h16;
  localparam logic [7:0] OFS_HOLD_PRE = 8'h17;
  localparam logic [7:0] OFS_HOLD_POST = 8'h18;
  localparam logic [7:0] OFS_TEST = 8'h19;
  localparam logic [7:0] OFS_LOOP_A = 8'h1a;
  localparam logic [7:0] OFS_LOOP_GAIN = 8'h1b;
  localparam logic [7:0] OFS_CHROMA = 8'h1c;
  localparam logic [7:0] OFS_KEY_STAT = 8'h1d;
  localparam logic [7:0] OFS_FIXED_B = 8'h1e;
  localparam logic [7:0] OFS_FIXED_C = 8'h1f;
  localparam logic [7:0] OFS_KEY_PORT = 8'h20;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [3:0] RST_IFACE_SYNC = 4'h1;
  localparam logic [7:0] RST_SEP_THRESH = 8'h20;
  localparam logic [7:0] RST_MISC_A = 8'h10;
  localparam logic [7:0] RST_SLICER = 8'hbc;
  localparam logic [7:0] RST_HOLD_PRE = 8'h00;
  localparam logic [7:0] RST_HOLD_POST = 8'h00;
  localparam logic [7:0] RST_TEST = 8'h00;
  localparam logic [7:0] RST_LOOP_A = 8'hff;
  localparam logic [7:0] RST_LOOP_GAIN = 8'h00;
  localparam logic [7:0] RST_CHROMA = 8'h07;
  localparam logic [7:0] RST_FIXED_B = 8'hff;
  localparam logic [7:0] RST_FIXED_C = 8'h84;
  localparam logic [7:0] RST_KEY_PORT = 8'h08;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_VSYNC_OVR = 3;
  localparam int BIT_VSYNC_SEL = 2;
  localparam int BIT_HOLD_SRC = 1;
  localparam int BIT_PWR_N = 0;
  localparam int BIT_SCAN_EN = 2;
  localparam int BIT_HOLD_POL_OVR = 1;
  localparam int BIT_HSYNC_POL_OVR = 0;
  localparam int BIT_CBCR_ORDER = 2;
  localparam int BIT_FMT_444 = 0;
  localparam int BIT_KEY_ADDR = 7;
  localparam int BIT_PIN_SEL = 6;
  localparam int BIT_BW_CTRL = 5;
  localparam int BIT_KEY_DRIVE = 4;
  localparam int BIT_OSC_INT = 3;

  // key port serial addresses (8-bit write form)
  localparam logic [7:0] KEY_ADDR_LO = 8'h74;
  localparam logic [7:0] KEY_ADDR_HI = 8'h76;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK,
    ST_WR, ST_WR_ACK, ST_RD, ST_RD_ACK
  } drscr_state_e;

  typedef struct packed {
    logic [7:0] loop_config_a;
    logic [7:0] loop_gain_mode;
    logic [4:0] loop_gain_b;
    logic [4:0] slicer_threshold;
    logic [7:0] holdover_pre_lines;
    logic [7:0] holdover_post_lines;
    logic [7:0] factory_test;
    logic [7:0] fixed_b;
    logic [7:0] fixed_c;
    logic scan_enable;
    logic output_444;
    logic cbcr_order;
    logic sampling_alt;
    logic bandwidth_low;
    logic osc_internal;
    logic full_power_down_n;
  } drscr_cfg_s;

endpackage

// *** verif/drscr_host.sv ***
// two-wire serial host model for the register bank's bus
`timescale 1ns/1ps
module drscr_host #(
  parameter logic [6:0] DEV = 7'h4c,
  parameter int HALF = 6
) (
  input wire logic sys_clk,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic hw();
    repeat (HALF) @(posedge sys_clk);
  endtask
  // sda moves only mid-way through scl low, clear of both edges
  task automatic put_bit(input logic b);
    sda_low <= !b;
    hw();
    scl_low <= 1'b0;
    hw();
    scl_low <= 1'b1;
    hw();
  endtask
  task automatic get_bit(output logic b);
    sda_low <= 1'b0;
    hw();
    scl_low <= 1'b0;
    hw();
    b = sda;
    scl_low <= 1'b1;
    hw();
  endtask
  // serves as first and repeated start
  task automatic start();
    sda_low <= 1'b0;
    hw();
    scl_low <= 1'b0;
    hw();
    sda_low <= 1'b1;
    hw();
    scl_low <= 1'b1;
    hw();
  endtask
  task automatic stop();
    sda_low <= 1'b1;
    hw();
    scl_low <= 1'b0;
    hw();
    sda_low <= 1'b0;
    hw();
  endtask
  task automatic tx(input logic [7:0] v, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i]);
    end
    get_bit(b);
    ack = !b;
  endtask
  task automatic write_reg(input logic [6:0] a, input logic [7:0] s, input logic [7:0] d,
                           output logic ack);
    logic k0, k1, k2;
    start();
    tx({a, 1'b0}, k0);
    tx(s, k1);
    tx(d, k2);
    stop();
    ack = k0 & k1 & k2;
  endtask
  // single byte read, ended with a not-acknowledge
  task automatic read_reg(input logic [7:0] s, output logic [7:0] d, output logic ack);
    logic k0, k1, k2;
    start();
    tx({DEV, 1'b0}, k0);
    tx(s, k1);
    start();
    tx({DEV, 1'b1}, k2);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(1'b1);
    stop();
    ack = k0 & k1 & k2;
  endtask
endmodule // drscr_host

// *** verif/drscr_regs_asserts.sv ***
// port-level checks for the sync, holdover and key-port register bank
`timescale 1ns/1ps
module drscr_regs_asserts (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic raw_vsync,
  input wire logic holdover_pin,
  input wire logic auto_vsync_from_sep,
  input wire logic vsync_out,
  input wire logic sep_sync_out,
  input wire logic holdover_src,
  input wire logic det_hsync_pol,
  input wire logic det_holdover_pol,
  input wire logic hsync_pol,
  input wire logic holdover_pol,
  input wire logic key_clock_drive,
  input wire logic general_control_output_three,
  input wire logic [6:0] key_port_addr,
  input wire logic shared_pin_out,
  input wire logic shared_pin_oe,
  input wire logic key_memory_clock_out,
  input wire logic key_memory_clock_oe,
  input wire logic osc_use_internal,
  input wire drscr_pkg::drscr_cfg_s cfg
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  reset_values_a: assert property ($past(rst) |-> cfg.loop_config_a == 8'hff
    && cfg.fixed_b == 8'hff && cfg.fixed_c == 8'h84 && cfg.slicer_threshold == 5'h17
    && cfg.holdover_pre_lines == 8'h00 && cfg.holdover_post_lines == 8'h00
    && !cfg.scan_enable && cfg.output_444 && cfg.full_power_down_n && osc_use_internal)
    else $error("register field wrong just after reset");
  key_addr_a: assert property (key_port_addr == 7'h3a || key_port_addr == 7'h3b)
    else $error("key port address outside its two values");
  key_clock_a: assert property (key_memory_clock_oe |-> key_clock_drive
    && !key_memory_clock_out) else $error("key clock driven without a request");
  shared_pin_a: assert property (shared_pin_out |-> shared_pin_oe
    && general_control_output_three) else $error("shared pin high without its source");
  pol_default_a: assert property ($past(rst) |-> hsync_pol == det_hsync_pol
    && holdover_pol == det_holdover_pol) else $error("polarity not detected after reset");
  hold_default_a: assert property ($past(rst) |-> holdover_src == holdover_pin)
    else $error("holdover source not the pin after reset");
  vsync_auto_a: assert property ($past(rst) |-> vsync_out ==
    (auto_vsync_from_sep ? sep_sync_out : raw_vsync)) else $error("vsync not automatic");
  cfg_quiet_a: assert property (scl_in [*8] |-> $stable(cfg))
    else $error("configuration moved while the bus clock stood high");
endmodule // drscr_regs_asserts

bind drscr_regs drscr_regs_asserts i_drscr_regs_asserts (
  .sys_clk, .rst, .scl_in, .raw_vsync, .holdover_pin, .auto_vsync_from_sep, .vsync_out,
  .sep_sync_out, .holdover_src, .det_hsync_pol, .det_holdover_pol, .hsync_pol,
  .holdover_pol, .key_clock_drive, .general_control_output_three, .key_port_addr,
  .shared_pin_out, .shared_pin_oe, .key_memory_clock_out, .key_memory_clock_oe,
  .osc_use_internal, .cfg
);

// *** verif/drscr_regs_tb.sv ***
// self-checking bench for the sync, holdover and key-port register bank
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    n_compared++; \
    if ((g) !== (e)) begin \
      fail_count++; \
      $display("unexpected %s expected %h seen %h", nm, e, g); \
    end \
  end
module drscr_regs_tb;
  logic sys_clk = 1'b0, rst = 1'b1, k;
  logic raw_vsync = 1'b1, composite_sync = 1'b0, holdover_pin = 1'b1;
  logic auto_vsync_from_sep = 1'b0, host_hsync_pol = 1'b1, host_holdover_pol = 1'b0;
  logic det_hsync_pol = 1'b0, det_holdover_pol = 1'b1, vsync_out_pol = 1'b0;
  logic keys_detected = 1'b0, key_data_drive = 1'b0, key_clock_drive = 1'b0;
  logic general_control_output_three = 1'b1;
  logic sda_out, sda_oe, vsync_out, sep_sync_out, holdover_src, hsync_pol, holdover_pol;
  logic shared_pin_out, shared_pin_oe, key_memory_clock_out, key_memory_clock_oe;
  logic osc_use_internal;
  logic [6:0] key_port_addr;
  drscr_pkg::drscr_cfg_s cfg;
  wire scl_low, sda_low;
  wire scl_in = !scl_low;
  wire sda_in = !(sda_low || (sda_oe && !sda_out));
  int fail_count = 0;
  int n_compared = 0;
  // offset, value written, value read back
  logic [23:0] rows [13] = '{24'h13_40_40, 24'h14_17_17, 24'h16_a8_a8, 24'h17_05_05,
    24'h18_03_03, 24'h19_00_00, 24'h1a_41_41, 24'h1b_10_10, 24'h1c_2c_2c, 24'h1e_ff_ff,
    24'h1f_84_84, 24'h20_d8_d8, 24'h12_0d_0d};
  logic [15:0] rv [13] = '{{8'h12, 4'h0, drscr_pkg::RST_IFACE_SYNC},
    {8'h13, drscr_pkg::RST_SEP_THRESH}, {8'h14, drscr_pkg::RST_MISC_A},
    {8'h16, drscr_pkg::RST_SLICER}, {8'h17, drscr_pkg::RST_HOLD_PRE},
    {8'h18, drscr_pkg::RST_HOLD_POST}, {8'h19, drscr_pkg::RST_TEST},
    {8'h1a, drscr_pkg::RST_LOOP_A}, {8'h1b, drscr_pkg::RST_LOOP_GAIN},
    {8'h1c, drscr_pkg::RST_CHROMA}, {8'h1e, drscr_pkg::RST_FIXED_B},
    {8'h1f, drscr_pkg::RST_FIXED_C}, {8'h20, drscr_pkg::RST_KEY_PORT}};

  drscr_regs i_drscr_regs (.sys_clk, .rst, .scl_in, .sda_in, .sda_out, .sda_oe, .raw_vsync,
    .composite_sync, .holdover_pin, .auto_vsync_from_sep, .vsync_out, .sep_sync_out,
    .holdover_src, .host_hsync_pol, .host_holdover_pol, .det_hsync_pol, .det_holdover_pol,
    .vsync_out_pol, .hsync_pol, .holdover_pol, .keys_detected, .key_data_drive,
    .key_clock_drive, .general_control_output_three, .key_port_addr, .shared_pin_out,
    .shared_pin_oe, .key_memory_clock_out, .key_memory_clock_oe, .osc_use_internal, .cfg);
  drscr_host i_drscr_host (.sys_clk(sys_clk), .sda(sda_in), .scl_low(scl_low),
    .sda_low(sda_low));

  always #10 sys_clk = ~sys_clk;

  task automatic complete_run();
    if (fail_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] s, input logic [7:0] d);
    logic a;
    i_drscr_host.write_reg(7'h4c, s, d, a);
    `CHK("write ack", 1'b1, a)
  endtask
  task automatic rd(input logic [7:0] s, input logic [7:0] e);
    logic [7:0] v;
    logic a;
    i_drscr_host.read_reg(s, v, a);
    `CHK("read ack", 1'b1, a)
    `CHK($sformatf("register %h", s), e, v)
  endtask

  initial begin
    repeat (80000) @(posedge sys_clk);
    fail_count++;
    complete_run();
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    `CHK("vsync select", sep_sync_out, vsync_out)
    `CHK("holdover pin", 1'b1, holdover_src)
    `CHK("hsync polarity", 1'b1, hsync_pol)
    `CHK("holdover polarity", 1'b0, holdover_pol)
    `CHK("scan", 1'b1, cfg.scan_enable)
    `CHK("slicer", 5'h15, cfg.slicer_threshold)
    `CHK("format", 1'b0, cfg.output_444)
    `CHK("key address", 7'h3b, key_port_addr)
    `CHK("oscillator", 1'b1, osc_use_internal)
    holdover_pin <= 1'b0;
    wr(8'h12, 8'h0a);
    `CHK("vsync raw", 1'b1, vsync_out)
    `CHK("holdover vsync", 1'b1, holdover_src)
    `CHK("power down", 1'b0, cfg.full_power_down_n)
    auto_vsync_from_sep <= 1'b1;
    wr(8'h12, 8'h01);
    `CHK("vsync auto", 1'b0, vsync_out)
    det_hsync_pol <= 1'b1;
    wr(8'h15, 8'h1f);
    rd(8'h15, 8'ha0);
    keys_detected <= 1'b1;
    wr(8'h1d, 8'h00);
    rd(8'h1d, 8'h01);
    keys_detected <= 1'b0;
    rd(8'h1d, 8'h00);
    i_drscr_host.write_reg(7'h4d, 8'h17, 8'h55, k);
    `CHK("foreign ack", 1'b0, k)
    rd(8'h17, 8'h05);
    rd(8'h30, 8'h00);
    key_data_drive <= 1'b1;
    key_clock_drive <= 1'b1;
    repeat (2) @(posedge sys_clk);
    `CHK("data enable", 1'b1, shared_pin_oe)
    `CHK("data level", 1'b0, shared_pin_out)
    `CHK("clock enable", 1'b1, key_memory_clock_oe)
    wr(8'h20, 8'h48);
    `CHK("data released", 1'b0, shared_pin_oe)
    `CHK("clock released", 1'b0, key_memory_clock_oe)
    `CHK("key address low", 7'h3a, key_port_addr)
    wr(8'h20, 8'h00);
    `CHK("control pin", 1'b1, shared_pin_out)
    `CHK("external osc", 1'b0, osc_use_internal)
    composite_sync <= 1'b1;
    repeat (30) @(posedge sys_clk);
    composite_sync <= 1'b0;
    repeat (10) @(posedge sys_clk);
    `CHK("short pulse", 1'b0, sep_sync_out)
    composite_sync <= 1'b1;
    repeat (60) @(posedge sys_clk);
    `CHK("before count", 1'b0, sep_sync_out)
    repeat (12) @(posedge sys_clk);
    `CHK("after count", 1'b1, sep_sync_out)
    rst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    foreach (rv[i]) begin
      rd(rv[i][15:8], rv[i][7:0]);
    end
    complete_run();
  end
endmodule // drscr_regs_tb
